/* hw/vbf_link.v */
// vpw link: rx noise filter, symbol decode, framing, crc, tx encoder
//
// Contract
// RQ1: sample rx line on link clock rise
// RQ2: count up/down on following fall edge
// RQ3: at 15 set output, saturate high
// RQ4: at 0 clear output, saturate low
// RQ5: output holds until opposite end reached
// RQ6: clean edge reaches output in 15-16 periods
// RQ7: filtered too-short pulses flag invalid symbol
// RQ8: at most 12 bytes, msb first
// RQ9: 200 us sof, excluded from crc
// RQ10: transmit needs at least one data byte
// RQ11: crc appended on tx, checked on rx
// RQ12: crc poly 0x1d, init all ones, serial
// RQ13: tx crc is inverted remainder, msb first
// RQ14: rx remainder not c4 sets crc error
// RQ15: 200 us passive is eod, no flag
// RQ16: 280 us passive is eof, sets flag
// RQ17: optional in-frame response accepted
// RQ18: symbol times for 10.4 kbps, link clock base
// RQ19: reset puts filter at zero, output low
`timescale 1ns/1ps
`include "vbf_consts.vh"
module vbf_link #(
  parameter DIV = `VBF_LINK_DIV
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       rx_line_input,
  output reg        tx_line_output,
  input  wire [7:0] tx_data,
  input  wire       tx_last,
  input  wire       tx_valid,
  output wire       tx_ready,
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  output reg        rx_eod,
  input  wire       flag_clr,
  output reg  [2:0] state_vector_register,
  output wire       rx_filtered,
  output wire       tx_busy
);
  // ----------------------------------------------------------------
  // timing counts in link clock periods
  // ----------------------------------------------------------------
  localparam integer I_SHORT = `VBF_US2TK(`VBF_SHORT_US);
  localparam integer I_LONG  = `VBF_US2TK(`VBF_LONG_US);
  localparam integer I_SOF   = `VBF_US2TK(`VBF_SOF_US);
  localparam integer I_EOF   = `VBF_US2TK(`VBF_RX_BRK_US);
  localparam integer I_IFS   = `VBF_US2TK(`VBF_IFS_US);
  localparam integer I_MIN   = `VBF_US2TK(`VBF_RX_MIN_US);
  localparam integer I_SL    = `VBF_US2TK(`VBF_RX_SL_US);
  localparam integer I_LS    = `VBF_US2TK(`VBF_RX_LS_US);
  localparam integer I_HALF  = DIV / 2;
  localparam integer I_DIV1  = DIV - 1;
  localparam [9:0]   C_SHORT = I_SHORT[9:0];
  localparam [9:0]   C_LONG  = I_LONG[9:0];
  localparam [9:0]   C_SOF   = I_SOF[9:0];
  localparam [9:0]   C_EOF   = I_EOF[9:0];
  localparam [9:0]   C_IFS   = I_IFS[9:0];
  localparam [9:0]   C_MIN   = I_MIN[9:0];
  localparam [9:0]   C_SL    = I_SL[9:0];
  localparam [9:0]   C_LS    = I_LS[9:0];
  localparam [9:0]   C_DIV1  = I_DIV1[9:0];
  localparam [9:0]   C_HALF  = I_HALF[9:0];

  // symbol classes
  localparam [2:0] K_BAD = 3'h0;
  localparam [2:0] K_SH  = 3'h1;
  localparam [2:0] K_LG  = 3'h2;
  localparam [2:0] K_SOF = 3'h3;
  localparam [2:0] K_BRK = 3'h4;

  // rx states
  localparam [3:0] R_IDLE = 4'h1;
  localparam [3:0] R_DATA = 4'h2;
  localparam [3:0] R_IFR  = 4'h4;
  localparam [3:0] R_NB   = 4'h8;

  // tx states
  localparam [2:0] T_IDLE = 3'h1;
  localparam [2:0] T_SOF  = 3'h2;
  localparam [2:0] T_BIT  = 3'h4;

  function [7:0] crc_step;
    input [7:0] crc;
    input       bitv;
    begin
      crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ bitv) ? `VBF_CRC_POLY : 8'h00); // RQ12
    end
  endfunction

  function [2:0] sym_class;
    input [9:0] len;
    begin
      if (len < C_MIN) begin
        sym_class = K_BAD;
      end else if (len < C_SL) begin
        sym_class = K_SH;
      end else if (len < C_LS) begin
        sym_class = K_LG;
      end else if (len < C_EOF) begin
        sym_class = K_SOF;
      end else begin
        sym_class = K_BRK;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // link clock enables
  // ----------------------------------------------------------------
  reg  [9:0] div_q;
  wire       rise_en = (div_q == 10'h000);
  wire       fall_en = (div_q == C_HALF);

  always @(posedge ref_clk) begin
    if (!rst_n || div_q == C_DIV1) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // rx digital filter
  // ----------------------------------------------------------------
  reg       s1_q;
  reg       s2_q;
  reg       samp_q;
  reg [3:0] fcnt_q;
  reg       filt_q;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      samp_q <= 1'b0;
      fcnt_q <= `VBF_FILT_MIN; // RQ19
      filt_q <= 1'b0; // RQ19
    end else begin
      s1_q <= rx_line_input;
      s2_q <= s1_q;
      if (rise_en) begin
        samp_q <= s2_q; // RQ1
      end
      if (fall_en) begin
        // saturating walk gives the 15-16 period delay
        if (samp_q && fcnt_q != `VBF_FILT_MAX) begin
          fcnt_q <= fcnt_q + 4'h1; // RQ2 RQ6
        end else if (!samp_q && fcnt_q != `VBF_FILT_MIN) begin
          fcnt_q <= fcnt_q - 4'h1; // RQ2 RQ6
        end
        if (samp_q && fcnt_q == `VBF_FILT_MAX - 4'h1) begin
          filt_q <= 1'b1; // RQ3 RQ5
        end else if (!samp_q && fcnt_q == `VBF_FILT_MIN + 4'h1) begin
          filt_q <= 1'b0; // RQ4 RQ5
        end
      end
    end
  end

  assign rx_filtered = filt_q;

  // ----------------------------------------------------------------
  // rx symbol decode and framing
  // ----------------------------------------------------------------
  reg  [3:0] rst_q;
  reg        fprev_q;
  reg  [9:0] dur_q;
  reg  [7:0] rsh_q;
  reg  [2:0] rbit_q;
  reg  [3:0] rbytes_q;
  reg  [7:0] rcrc_q;
  reg        set_crc;
  reg        set_eof;
  reg        set_inv;
  wire       edge_ev = filt_q ^ fprev_q;
  wire [2:0] cls     = sym_class(dur_q);
  wire       is_bit  = (cls == K_SH) || (cls == K_LG);
  // passive long is 1, active long is 0
  wire       bitv    = (cls == K_LG) ^ fprev_q;
  wire       rx_idle = !filt_q && (dur_q >= C_IFS) && (rst_q == R_IDLE);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_q    <= R_IDLE;
      fprev_q  <= 1'b0;
      dur_q    <= 10'h000;
      rsh_q    <= 8'h00;
      rbit_q   <= 3'h0;
      rbytes_q <= 4'h0;
      rcrc_q   <= `VBF_CRC_INIT;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      rx_eod   <= 1'b0;
      set_crc  <= 1'b0;
      set_eof  <= 1'b0;
      set_inv  <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_eod   <= 1'b0;
      set_crc  <= 1'b0;
      set_eof  <= 1'b0;
      set_inv  <= 1'b0;
      fprev_q  <= filt_q;
      if (edge_ev) begin
        dur_q <= 10'h000;
      end else if (rise_en && dur_q != 10'h3ff) begin
        dur_q <= dur_q + 10'h001; // RQ18
      end
      case (rst_q)
        R_IDLE: begin
          if (edge_ev && fprev_q && cls == K_SOF) begin
            rst_q    <= R_DATA; // RQ9
            rcrc_q   <= `VBF_CRC_INIT; // RQ9 RQ12
            rbit_q   <= 3'h0;
            rbytes_q <= 4'h0;
          end else if (edge_ev && fprev_q && cls == K_BAD) begin
            set_inv <= 1'b1; // RQ7
          end
        end
        R_DATA: begin
          if (edge_ev) begin
            if (!is_bit || rbytes_q == `VBF_MAX_BYTES) begin
              set_inv <= 1'b1; // RQ7 RQ8
              rst_q   <= R_IDLE;
            end else begin
              rsh_q  <= {rsh_q[6:0], bitv}; // RQ8
              rcrc_q <= crc_step(rcrc_q, bitv); // RQ11
              rbit_q <= rbit_q + 3'h1;
              if (rbit_q == 3'h7) begin
                rx_data  <= {rsh_q[6:0], bitv};
                rx_valid <= 1'b1;
                rbytes_q <= rbytes_q + 4'h1;
              end
            end
          end else if (!filt_q && dur_q == C_LS) begin
            if (rbit_q == 3'h0 && rbytes_q != 4'h0) begin
              rx_eod  <= 1'b1; // RQ15
              set_crc <= (rcrc_q != `VBF_CRC_GOOD); // RQ14
              rst_q   <= R_IFR;
            end else begin
              set_inv <= 1'b1;
              rst_q   <= R_IDLE;
            end
          end
        end
        R_IFR: begin
          if (edge_ev) begin
            rst_q <= R_NB; // RQ17
          end else if (!filt_q && dur_q == C_EOF) begin
            set_eof <= 1'b1; // RQ16
            rst_q   <= R_IDLE;
          end
        end
        R_NB: begin
          if (edge_ev) begin
            if (is_bit) begin
              rst_q  <= R_DATA; // RQ17
              rcrc_q <= `VBF_CRC_INIT;
              rbit_q <= 3'h0;
            end else begin
              set_inv <= 1'b1;
              rst_q   <= R_IDLE;
            end
          end
        end
        default: begin
          rst_q <= R_IDLE;
        end
      endcase
    end
  end

  // sticky flags: {invalid, eof, crc error}; a set beats a clear
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_vector_register <= 3'h0;
    end else begin
      state_vector_register <= (flag_clr ? 3'h0 : state_vector_register)
                               | {set_inv, set_eof, set_crc}; // RQ14 RQ16
    end
  end

  // ----------------------------------------------------------------
  // tx fifo and encoder
  // ----------------------------------------------------------------
  wire [8:0] f_data;
  wire       f_vld;
  reg        f_pop;

  vbf_fifo #(
    .W  (9),
    .D  (`VBF_FIFO_DEPTH),
    .AW (3)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_data   ({tx_last, tx_data}),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_vld),
    .out_ready (f_pop)
  );

  reg  [2:0] tst_q;
  reg  [9:0] tcnt_q;
  reg  [7:0] tsh_q;
  reg  [2:0] tbit_q;
  reg  [3:0] tbytes_q;
  reg  [7:0] tcrc_q;
  reg        tlast_q;
  reg        tcrcph_q;
  wire       tk_end = rise_en && (tcnt_q == 10'h001);
  reg        ld;
  reg        ld_v;
  reg        ld_lvl;
  reg        ld_new;
  reg        ld_crc;
  reg  [7:0] ld_byte;

  // next bit to drive at the end of the current symbol
  always @* begin
    ld      = 1'b0;
    ld_v    = 1'b0;
    ld_lvl  = 1'b0;
    ld_new  = 1'b0;
    ld_crc  = 1'b0;
    ld_byte = tsh_q;
    f_pop   = 1'b0;
    if (tk_end && tst_q == T_SOF) begin
      ld      = 1'b1;
      ld_new  = 1'b1;
      ld_byte = f_data[7:0]; // RQ10
      f_pop   = 1'b1;
    end else if (tk_end && tst_q == T_BIT) begin
      if (tbit_q != 3'h7) begin
        ld      = 1'b1;
        ld_byte = {tsh_q[6:0], 1'b0};
        ld_lvl  = ~tbit_q[0];
      end else if (!tcrcph_q && f_vld && !tlast_q
                   && tbytes_q < `VBF_MAX_BYTES - 4'h1) begin
        ld      = 1'b1;
        ld_new  = 1'b1;
        ld_byte = f_data[7:0];
        f_pop   = 1'b1;
      end else if (!tcrcph_q) begin
        ld      = 1'b1;
        ld_crc  = 1'b1;
        ld_new  = 1'b1;
        ld_byte = ~tcrc_q; // RQ13
      end
    end
    ld_v = ld_byte[7]; // RQ8 RQ13
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tst_q          <= T_IDLE;
      tcnt_q         <= 10'h000;
      tsh_q          <= 8'h00;
      tbit_q         <= 3'h0;
      tbytes_q       <= 4'h0;
      tcrc_q         <= `VBF_CRC_INIT;
      tlast_q        <= 1'b0;
      tcrcph_q       <= 1'b0;
      tx_line_output <= 1'b0;
    end else begin
      if (rise_en && tcnt_q != 10'h000) begin
        tcnt_q <= tcnt_q - 10'h001;
      end
      case (tst_q)
        T_IDLE: begin
          if (f_vld && rx_idle && rise_en) begin
            tst_q          <= T_SOF;
            tx_line_output <= 1'b1; // RQ9
            tcnt_q         <= C_SOF; // RQ9
            tcrc_q         <= `VBF_CRC_INIT; // RQ12
            tbytes_q       <= 4'h0;
            tcrcph_q       <= 1'b0;
          end
        end
        T_SOF, T_BIT: begin
          if (ld) begin
            tst_q          <= T_BIT;
            tx_line_output <= ld_lvl;
            tcnt_q         <= (ld_v ^ ld_lvl) ? C_LONG : C_SHORT; // RQ18
            tsh_q          <= ld_byte;
            if (!(ld_crc || tcrcph_q)) begin
              tcrc_q <= crc_step(tcrc_q, ld_v); // RQ11
            end
            if (ld_new) begin
              tbit_q   <= 3'h0;
              tcrcph_q <= ld_crc;
              if (!ld_crc) begin
                tlast_q  <= f_data[8];
                tbytes_q <= tbytes_q + 4'h1;
              end
            end else begin
              tbit_q <= tbit_q + 3'h1;
            end
          end else if (tk_end) begin
            tst_q          <= T_IDLE;
            tx_line_output <= 1'b0;
          end
        end
        default: begin
          tst_q <= T_IDLE;
        end
      endcase
    end
  end

  assign tx_busy = (tst_q != T_IDLE);
endmodule // vbf_link

/* hw/vbf_consts.vh */
// constants for the vpw link filter, framing and fifo
`ifndef VBF_CONSTS_VH
`define VBF_CONSTS_VH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define VBF_REF_MHZ      250
`define VBF_LINK_DIV     250
`define VBF_US2TK(us)    ((us) * `VBF_REF_MHZ / `VBF_LINK_DIV)
`define VBF_BIT_RATE_BPS 10400

// ----------------------------------------------------------------
// symbol times in microseconds
// ----------------------------------------------------------------
`define VBF_SHORT_US     (2000000 / (3 * `VBF_BIT_RATE_BPS))
`define VBF_LONG_US      (2 * `VBF_SHORT_US)
`define VBF_SOF_US       200
`define VBF_EOF_US       280
`define VBF_IFS_US       300
`define VBF_RX_MIN_US    34
`define VBF_RX_SL_US     96
`define VBF_RX_LS_US     163
`define VBF_RX_BRK_US    239

// ----------------------------------------------------------------
// filter, crc, framing and fifo
// ----------------------------------------------------------------
`define VBF_FILT_MAX     4'hf
`define VBF_FILT_MIN     4'h0
`define VBF_CRC_POLY     8'h1d
`define VBF_CRC_INIT     8'hff
`define VBF_CRC_GOOD     8'hc4
`define VBF_MAX_BYTES    4'hc
`define VBF_FIFO_DEPTH   8

`endif

/* hw/vbf_fifo.v */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module vbf_fifo #(
  parameter W  = 9,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW:0]  wp_q;
  reg [AW:0]  rp_q;
  wire        do_wr;
  wire        do_rd;

  assign in_ready  = (wp_q - rp_q) != D[AW:0];
  assign out_valid = wp_q != rp_q;
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  assign out_data  = mem_q[rp_q[AW-1:0]];

  always @(posedge ref_clk) begin
    if (do_wr) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // vbf_fifo

/* sim/vbf_link_chk.sv */
// checker: port-level assertions for the vpw link
`timescale 1ns/1ps
module vbf_link_chk #(
  parameter DIV = 250
) (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       rx_line_input,
  input wire       tx_line_output,
  input wire [7:0] tx_data,
  input wire       tx_last,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire [7:0] rx_data,
  input wire       rx_valid,
  input wire       rx_eod,
  input wire       flag_clr,
  input wire [2:0] state_vector_register,
  input wire       rx_filtered,
  input wire       tx_busy
);
  // ----------------------------------------------------------------
  // run-length counters
  // ----------------------------------------------------------------
  logic [19:0] hi_q;
  logic [19:0] lo_q;
  logic [19:0] act_q;
  logic [19:0] pas_q;
  logic        sof_q;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hi_q  <= '0;
      lo_q  <= '0;
      act_q <= '0;
      pas_q <= '0;
      sof_q <= 1'b1;
    end else begin
      hi_q  <= rx_line_input ? hi_q + 1 : '0;
      lo_q  <= rx_line_input ? '0 : lo_q + 1;
      act_q <= tx_line_output ? act_q + 1 : '0;
      pas_q <= rx_filtered ? '0 : pas_q + 1;
      // first active pulse of a frame is the start symbol
      sof_q <= !tx_busy ? 1'b1 : ((act_q != 0 && !tx_line_output) ? 1'b0 : sof_q);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RST_STATE:
    assert property (disable iff (1'b0) !rst_n |=> !tx_line_output && !rx_filtered
      && state_vector_register == 3'h0 && !tx_busy) else $error("reset state wrong");
  AST_FILT_HI:
    assert property (hi_q > 17 * DIV |-> rx_filtered) else $error("filter stuck low");
  AST_FILT_LO:
    assert property (lo_q > 17 * DIV |-> !rx_filtered) else $error("filter stuck high");
  AST_SOF_LEN:
    assert property ($fell(tx_line_output) && sof_q |-> act_q == 200 * DIV)
      else $error("start symbol length wrong");
  AST_BIT_LEN:
    assert property ($fell(tx_line_output) && !sof_q |-> act_q == 64 * DIV
      || act_q == 128 * DIV) else $error("active bit length wrong");
  AST_TX_IDLE:
    assert property (!tx_busy |-> !tx_line_output) else $error("line active while idle");
  AST_RXV_EDGE:
    assert property (rx_valid |-> !rx_filtered && ($past(rx_filtered)
      || $past(rx_filtered, 2)) ##1 !rx_valid) else $error("byte strobe misplaced");
  AST_EOD_TIME:
    assert property (rx_eod |-> pas_q >= 161 * DIV && pas_q <= 165 * DIV ##1 !rx_eod)
      else $error("end of data misplaced");
  AST_EOF_TIME:
    assert property ($rose(state_vector_register[1]) |-> !rx_filtered
      && pas_q >= 237 * DIV && pas_q <= 241 * DIV) else $error("end of frame misplaced");
  AST_FLAG_STICKY:
    assert property (!flag_clr |=> (state_vector_register & $past(state_vector_register))
      == $past(state_vector_register)) else $error("flag lost without clear");
  AST_CRC_AT_EOD:
    assert property ($rose(state_vector_register[0]) |-> rx_eod || $past(rx_eod)
      || $past(rx_eod, 2)) else $error("crc flag away from end of data");

  COV_EOD: cover property (rx_eod);
  COV_CRC: cover property ($rose(state_vector_register[0]));
  COV_INV: cover property ($rose(state_vector_register[2]));
endmodule // vbf_link_chk

bind vbf_link vbf_link_chk #(.DIV(DIV)) vbf_link_chk_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .rx_line_input(rx_line_input),
  .tx_line_output(tx_line_output), .tx_data(tx_data), .tx_last(tx_last),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_eod(rx_eod), .flag_clr(flag_clr), .state_vector_register(state_vector_register),
  .rx_filtered(rx_filtered), .tx_busy(tx_busy));

/* sim/vbf_xcvr_model.sv */
// transceiver model: one bus shared by our transmitter and a remote node
`timescale 1ns/1ps
module vbf_xcvr_model (
  input  wire tx_line,
  input  wire remote_act,
  output wire rx_line
);
  // active level is dominant, so our own frames come back on the receive pin
  assign rx_line = tx_line | remote_act;
endmodule // vbf_xcvr_model

/* sim/vbf_link_tb.sv */
// testbench for the vpw link with a loopback transceiver model
`timescale 1ns/1ps
module vbf_link_tb;
  localparam int DIV = 4;
  logic       ref_clk     = 1'b0;
  logic       rst_n       = 1'b0;
  logic       remote_act  = 1'b0;
  logic [7:0] tx_data     = 8'h00;
  logic       tx_last     = 1'b0;
  logic       tx_valid    = 1'b0;
  logic       flag_clr    = 1'b0;
  logic       lvl         = 1'b0;
  wire        rx_line_input;
  wire        tx_line_output;
  wire        tx_ready;
  wire  [7:0] rx_data;
  wire        rx_valid;
  wire        rx_eod;
  wire  [2:0] sv;
  wire        rx_filtered;
  wire        tx_busy;
  int         fail_count  = 0;
  int         checks_done = 0;
  int         eod_n       = 0;
  logic [7:0] rxq[$];

  always #2 ref_clk = ~ref_clk;

  vbf_link #(.DIV(DIV)) vbf_link_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .rx_line_input(rx_line_input),
    .tx_line_output(tx_line_output), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_eod(rx_eod), .flag_clr(flag_clr), .state_vector_register(sv),
    .rx_filtered(rx_filtered), .tx_busy(tx_busy));
  vbf_xcvr_model vbf_xcvr_model_inst (
    .tx_line(tx_line_output), .remote_act(remote_act), .rx_line(rx_line_input));

  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
    end
    if (rx_eod === 1'b1) begin
      eod_n++;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic per(input int n);
    tick(n * DIV);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] crc_step(input logic [7:0] r, input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ b[k]) ? 8'h1d : 8'h00);
    end
    return r;
  endfunction
  task automatic clr();
    flag_clr = 1'b1;
    tick(1);
    flag_clr = 1'b0;
    tick(1);
  endtask
  task automatic wait_eof();
    int n;
    n = 0;
    while (sv[1] !== 1'b1 && n < 4000 * DIV) begin
      tick(1);
      n++;
    end
    if (n >= 4000 * DIV) begin
      fail_count++;
      $display("mismatch at %0t: no end of frame", $time);
      test_done();
    end
  endtask
  // remote node: level alternates, active one and passive zero are short
  task automatic send_byte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      remote_act = lvl;
      per((lvl ^ b[k]) ? 128 : 64);
      lvl = ~lvl;
    end
    remote_act = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({4'h0, tx_line_output, rx_filtered, tx_busy, tx_ready}, 8'h01);
    chk({5'h00, sv}, 8'h00);
  endtask
  task automatic t_filter();
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    per(300);
    remote_act = 1'b1;
    while (rx_filtered !== 1'b1 && n < 20 * DIV) begin
      tick(1);
      n++;
    end
    chk(8'(n >= 15 * DIV && n <= 16 * DIV + 4), 8'h01);
    if (n >= 20 * DIV) begin
      test_done();
    end
    // pulse of about 26 periods passes the filter but is no symbol
    per(10);
    remote_act = 1'b0;
    per(40);
    chk({7'h00, rx_filtered}, 8'h00);
    chk({5'h00, sv}, 8'h04);
    clr();
    chk({5'h00, sv}, 8'h00);
    remote_act = 1'b1;
    per(8);
    remote_act = 1'b0;
    for (int i = 0; i < 40 * DIV; i++) begin
      seen = seen | rx_filtered;
      tick(1);
    end
    chk({7'h00, seen}, 8'h00);
    chk({5'h00, sv}, 8'h00);
  endtask
  task automatic t_loop();
    per(300);
    rxq.delete();
    eod_n = 0;
    tx_data = 8'h12;
    tx_valid = 1'b1;
    tick(1);
    tx_data = 8'h34;
    tx_last = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    wait_eof();
    chk(8'(rxq.size()), 8'h03);
    chk(rxq[0], 8'h12);
    chk(rxq[1], 8'h34);
    chk(rxq[2], ~crc_step(crc_step(8'hff, 8'h12), 8'h34));
    chk(8'(eod_n), 8'h01);
    chk({5'h00, sv}, 8'h02);
  endtask
  task automatic t_remote(input logic [7:0] crc_fix, input logic [7:0] exp_sv);
    clr();
    per(300);
    rxq.delete();
    remote_act = 1'b1;
    per(200);
    lvl = 1'b0;
    send_byte(8'h12);
    send_byte(~crc_step(8'hff, 8'h12) ^ crc_fix);
    per(200);
    remote_act = 1'b1;
    per(64);
    lvl = 1'b0;
    send_byte(8'h5a);
    send_byte(~crc_step(8'hff, 8'h5a));
    wait_eof();
    chk(8'(rxq.size()), 8'h04);
    chk({5'h00, sv}, exp_sv);
  endtask
  // reset in mid-run: flags set, filter high, one word queued behind a busy bus
  task automatic t_mid_reset();
    remote_act = 1'b1;
    per(20);
    tx_data = 8'h77;
    tx_last = 1'b1;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    remote_act = 1'b0;
    chk({5'h00, sv}, 8'h00);
    chk({5'h00, rx_filtered, tx_busy, tx_ready}, 8'h01);
    // a queued word that survived reset would start a frame after the idle time
    per(340);
    chk({6'h00, tx_busy, tx_line_output}, 8'h00);
    chk({7'h00, rx_filtered}, 8'h00);
  endtask

  initial begin
    tick(3);
    rst_n = 1'b1;
    t_reset();
    t_filter();
    t_loop();
    t_remote(8'h00, 8'h02);
    t_remote(8'h01, 8'h03);
    t_mid_reset();
    test_done();
  end
endmodule // vbf_link_tb
